// ==== inc/pspg_pkg.sv ====
package pspg_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // one time-base count is about one nanosecond, so each clock adds the period in counts
  localparam logic [15:0] TB_STEP       = 16'h0008;
  localparam int unsigned DT_STEP_NS    = 4;
  localparam logic [15:0] DT_STEP_MASK  = 16'hFFFC;
  localparam int unsigned DT_MIN_NS     = 16;
  localparam logic [15:0] DT_MIN_VALUE  = 16'h0010;

  localparam logic [15:0] DUTY_MIN      = 16'h0010;
  localparam logic [15:0] DUTY_COARSE_HI = 16'h0040;
  localparam logic [15:0] DUTY_COARSE_MASK = 16'hFFF0;
  localparam logic [15:0] TRIG_MIN      = 16'h0008;

  localparam logic [1:0]  DTM_POSITIVE  = 2'h0;
  localparam logic [1:0]  DTM_NEGATIVE  = 2'h1;
  localparam logic [1:0]  DTM_DISABLED  = 2'h2;

  localparam int unsigned DT_CYC_W      = 14;

  // each dead time rounds up to whole clocks
  function automatic logic [DT_CYC_W-1:0] pspg_dt_cycles(input logic [15:0] value);
    logic [16:0] ns;
    ns = {1'b0, value & DT_STEP_MASK};
    pspg_dt_cycles = DT_CYC_W'((ns + 17'(CLK_PERIOD_NS - 1)) / 17'(CLK_PERIOD_NS));
  endfunction

endpackage

// ==== logic/pspg_dead_time.sv ====
`timescale 1ns/10ps
module pspg_dead_time
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          run,
  input  wire logic                          pwm_raw,
  input  wire logic                          dt_enable,
  input  wire logic [pspg_pkg::DT_CYC_W-1:0] dt_rise_cycles,
  input  wire logic [pspg_pkg::DT_CYC_W-1:0] dt_fall_cycles,
  output logic                               high_drive,
  output logic                               low_drive
);

  logic                          prev_q;
  logic [pspg_pkg::DT_CYC_W-1:0] cnt_q;
  logic [pspg_pkg::DT_CYC_W-1:0] delay;

  // rising edge of the raw wave delays the high side, falling edge the low side
  assign delay = pwm_raw ? dt_rise_cycles : dt_fall_cycles;

  always_ff @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      prev_q     <= 1'b0;
      cnt_q      <= '0;
      high_drive <= 1'b0;
      low_drive  <= 1'b0;
    end
    else
    begin
      prev_q <= pwm_raw;
      if (!dt_enable)
      begin
        high_drive <= pwm_raw;
        low_drive  <= !pwm_raw;
        cnt_q      <= '0;
      end
      else if (pwm_raw != prev_q && delay != '0)
      begin
        // both sides off first: the side turning on waits out the gap
        high_drive <= 1'b0;
        low_drive  <= 1'b0;
        cnt_q      <= delay - 1'b1;
      end
      else if (cnt_q != '0)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
      else
      begin
        high_drive <= pwm_raw;
        low_drive  <= !pwm_raw;
      end
    end
  end

endmodule

// ==== logic/pspg_generator.sv ====
`timescale 1ns/10ps
module pspg_generator
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        generator_enable,
  input  wire logic [1:0]  dead_time_mode,
  input  wire logic [15:0] dead_time_value,
  input  wire logic [15:0] alternate_dead_time_value,
  input  wire logic [15:0] master_period,
  input  wire logic [15:0] individual_period,
  input  wire logic        period_select,
  input  wire logic [15:0] master_duty,
  input  wire logic [15:0] individual_duty,
  input  wire logic        duty_select,
  input  wire logic [15:0] individual_trigger_compare,
  input  wire logic [15:0] special_event_compare,
  input  wire logic        trigger_select,
  input  wire logic        adc_trigger_enable,
  input  wire logic        trigger_irq_enable,
  input  wire logic        immediate_update,
  input  wire logic        current_reset_enable,
  input  wire logic        current_limit_in,
  input  wire logic        current_limit_override_enable,
  input  wire logic [1:0]  current_limit_level_bits,
  input  wire logic        fault_in,
  input  wire logic        fault_override_enable,
  input  wire logic [1:0]  fault_level_bits,
  input  wire logic        high_override_enable,
  input  wire logic        low_override_enable,
  input  wire logic [1:0]  override_level_bits,
  input  wire logic        high_pin_ownership,
  input  wire logic        low_pin_ownership,
  input  wire logic [1:0]  port_latch,
  input  wire logic [1:0]  port_direction_out,
  output logic             high_output,
  output logic             high_output_oe,
  output logic             low_output,
  output logic             low_output_oe,
  output logic             adc_trigger,
  output logic             trigger_irq
);

  // ****************************************************************
  // time base and buffered settings
  // ****************************************************************
  logic [15:0] cnt_q;
  logic [15:0] per_q;
  logic [15:0] duty_q;
  logic [15:0] cmp_q;
  logic [15:0] per_d;
  logic [15:0] duty_d;
  logic [15:0] cmp_d;
  logic [16:0] cnt_next;
  logic        period_end;
  logic        cl_reset;
  logic        restart;
  logic        load;
  logic        raw_q;
  logic        raw_prev_q;
  logic        hi_fell_q;

  assign per_d      = period_select ? individual_period : master_period;
  assign duty_d     = duty_select ? individual_duty : master_duty;
  assign cmp_d      = trigger_select ? special_event_compare : individual_trigger_compare;
  assign cnt_next   = {1'b0, cnt_q} + {1'b0, pspg_pkg::TB_STEP};
  assign period_end = cnt_next >= {1'b0, per_q};
  // current reset acts only in independent time base, after the high output fell
  assign cl_reset   = current_reset_enable && period_select && current_limit_in
                      && hi_fell_q;
  assign restart    = period_end || cl_reset;
  // immediate update bypasses the period-boundary buffering
  assign load       = restart || !generator_enable || immediate_update;

  function automatic logic [15:0] duty_effective(input logic [15:0] d, input logic [15:0] p);
    logic coarse;
    coarse = (d > pspg_pkg::DUTY_MIN && d < pspg_pkg::DUTY_COARSE_HI)
             || (d > p - pspg_pkg::DUTY_COARSE_HI && d < p - pspg_pkg::DUTY_MIN);
    if (d < pspg_pkg::DUTY_MIN)
      duty_effective = 16'h0000;
    else if (coarse)
      duty_effective = d & pspg_pkg::DUTY_COARSE_MASK;
    else
      duty_effective = d;
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst || !generator_enable)
      cnt_q <= 16'h0000;
    else if (restart)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_next[15:0];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      per_q  <= 16'h0000;
      duty_q <= 16'h0000;
      cmp_q  <= 16'h0000;
    end
    else if (load)
    begin
      per_q  <= per_d;
      duty_q <= duty_effective(duty_d, per_d);
      cmp_q  <= cmp_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || !generator_enable)
    begin
      raw_q      <= 1'b0;
      raw_prev_q <= 1'b0;
      hi_fell_q  <= 1'b0;
    end
    else
    begin
      raw_q      <= cnt_q < duty_q;
      raw_prev_q <= raw_q;
      if (restart)
        hi_fell_q <= 1'b0;
      else if (raw_prev_q && !raw_q)
        hi_fell_q <= 1'b1;
    end
  end

  // ****************************************************************
  // trigger
  // ****************************************************************
  logic trig_hit;

  // compare values under the minimum never fire
  assign trig_hit = generator_enable && cmp_q >= pspg_pkg::TRIG_MIN
                    && cmp_q >= cnt_q && {1'b0, cmp_q} < cnt_next;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      adc_trigger <= 1'b0;
      trigger_irq <= 1'b0;
    end
    else
    begin
      adc_trigger <= trig_hit && adc_trigger_enable;
      trigger_irq <= trig_hit && trigger_irq_enable;
    end
  end

  // ****************************************************************
  // dead time
  // ****************************************************************
  logic [pspg_pkg::DT_CYC_W-1:0] dt_pri_q;
  logic [pspg_pkg::DT_CYC_W-1:0] dt_alt_q;
  logic                          dt_enable;
  logic                          high_drive;
  logic                          low_drive;

  assign dt_enable = dead_time_mode == pspg_pkg::DTM_POSITIVE
                     || dead_time_mode == pspg_pkg::DTM_NEGATIVE;

  // capturing only while stopped keeps a running wave free of mid-gap changes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dt_pri_q <= '0;
      dt_alt_q <= '0;
    end
    else if (!generator_enable)
    begin
      dt_pri_q <= pspg_pkg::pspg_dt_cycles(dead_time_value);
      dt_alt_q <= pspg_pkg::pspg_dt_cycles(alternate_dead_time_value);
    end
  end

  pspg_dead_time u_dead_time
  (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .run            (generator_enable),
    .pwm_raw        (raw_q),
    .dt_enable      (dt_enable),
    .dt_rise_cycles (dt_pri_q),
    .dt_fall_cycles (dt_alt_q),
    .high_drive     (high_drive),
    .low_drive      (low_drive)
  );

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  logic [1:0] pin_d;
  logic [1:0] oe_d;

  always_comb
  begin
    pin_d = {high_drive, low_drive};
    if (high_override_enable)
      pin_d[1] = override_level_bits[1];
    if (low_override_enable)
      pin_d[0] = override_level_bits[0];
    if (current_limit_override_enable && current_limit_in)
      pin_d = current_limit_level_bits;
    if (fault_override_enable && fault_in)
      pin_d = fault_level_bits;
    oe_d = 2'b11;
    if (!high_pin_ownership)
    begin
      pin_d[1] = port_latch[1];
      oe_d[1]  = port_direction_out[1];
    end
    if (!low_pin_ownership)
    begin
      pin_d[0] = port_latch[0];
      oe_d[0]  = port_direction_out[0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      high_output    <= 1'b0;
      low_output     <= 1'b0;
      high_output_oe <= 1'b0;
      low_output_oe  <= 1'b0;
    end
    else
    begin
      high_output    <= pin_d[1];
      low_output     <= pin_d[0];
      high_output_oe <= oe_d[1];
      low_output_oe  <= oe_d[0];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_gap_no_overlap: assert property (dt_enable |-> !(high_drive && low_drive))
    else $error("both sides driven during dead-time mode");
  a_zero_gap_follow: assert property (generator_enable && $past(generator_enable)
      && !dt_enable |=> high_drive == $past(raw_q) && low_drive == !$past(raw_q))
    else $error("outputs not complementary without dead time");
  a_duty_low_zero: assert property (load && duty_d < pspg_pkg::DUTY_MIN |=> duty_q == 16'h0000)
    else $error("small duty not treated as zero");
  a_trig_min_none: assert property (adc_trigger |-> $past(cmp_q) >= pspg_pkg::TRIG_MIN)
    else $error("trigger fired below minimum compare");
  a_period_select: assert property (load && period_select |=> per_q == $past(individual_period))
    else $error("individual period not taken");
  a_owner_port: assert property (!high_pin_ownership |=> high_output == $past(port_latch[1])
      && high_output_oe == $past(port_direction_out[1]))
    else $error("port did not own high pin");
  a_fault_wins: assert property (high_pin_ownership && low_pin_ownership && fault_in
      && fault_override_enable |=> {high_output, low_output} == $past(fault_level_bits))
    else $error("fault override lost priority");
  a_cl_ignored: assert property (!hi_fell_q && !period_end && generator_enable
      |=> cnt_q == 16'h0000 || cnt_q == $past(cnt_q) + pspg_pkg::TB_STEP)
    else $error("current limit reset period before high fell");
  a_override_pair: assert property (high_pin_ownership && low_pin_ownership && !fault_in
      && !current_limit_in && high_override_enable && low_override_enable
      |=> {high_output, low_output} == $past(override_level_bits))
    else $error("override levels not on pins");

  c_trigger: cover property (adc_trigger);
  c_cl_reset: cover property (cl_reset);
  c_dead_gap: cover property (dt_enable && raw_q ##1 !raw_q ##[1:20] low_drive);
  c_override: cover property (high_override_enable && !low_override_enable);

endmodule

// ==== sim/pspg_generator_tb.sv ====
`timescale 1ns/10ps
module pspg_generator_tb;
  // ********
  // pins and stimulus
  // ********
  logic        clk = 1'h0, sys_rst = 1'h1, generator_enable = 1'h0, clear = 1'h1;
  logic        period_select = 1'h0, duty_select = 1'h0, trigger_select = 1'h0;
  logic        adc_trigger_enable = 1'h1, trigger_irq_enable = 1'h1;
  logic        immediate_update = 1'h0;
  logic        current_reset_enable = 1'h0, current_limit_in = 1'h0, fault_in = 1'h0;
  logic        current_limit_override_enable = 1'h0, fault_override_enable = 1'h0;
  logic        high_override_enable = 1'h0, low_override_enable = 1'h0;
  logic        high_pin_ownership = 1'h1, low_pin_ownership = 1'h1;
  logic [1:0]  dead_time_mode = 2'h2, current_limit_level_bits = 2'h0;
  logic [1:0]  fault_level_bits = 2'h0, override_level_bits = 2'h0;
  logic [1:0]  port_latch = 2'h0, port_direction_out = 2'h0;
  logic [15:0] dead_time_value = 16'h0010, alternate_dead_time_value = 16'h0010;
  logic [15:0] master_period = 16'h0100, individual_period = 16'h0100;
  logic [15:0] master_duty = 16'h0080, individual_duty = 16'h0080;
  logic [15:0] individual_trigger_compare = 16'h0040, special_event_compare = 16'h0050;
  logic        high_output, high_output_oe, low_output, low_output_oe;
  logic        adc_trigger, trigger_irq;
  int          adc_count, irq_count, shoot_count, len, hi, lo;
  int          num_errors = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;

  pspg_generator u_pspg_generator
  (
    .clk, .sys_rst, .generator_enable, .dead_time_mode, .dead_time_value,
    .alternate_dead_time_value, .master_period, .individual_period, .period_select,
    .master_duty, .individual_duty, .duty_select, .individual_trigger_compare,
    .special_event_compare, .trigger_select, .adc_trigger_enable, .trigger_irq_enable,
    .immediate_update, .current_reset_enable, .current_limit_in,
    .current_limit_override_enable, .current_limit_level_bits, .fault_in,
    .fault_override_enable, .fault_level_bits, .high_override_enable, .low_override_enable,
    .override_level_bits, .high_pin_ownership, .low_pin_ownership, .port_latch,
    .port_direction_out, .high_output, .high_output_oe, .low_output, .low_output_oe,
    .adc_trigger, .trigger_irq
  );

  pspg_power_stage u_pspg_power_stage
  (
    .clk, .clear, .high_output, .high_output_oe, .low_output, .low_output_oe,
    .adc_trigger, .trigger_irq, .adc_count, .irq_count, .shoot_count
  );

  // ********
  // access tasks
  // ********
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // dead times are only retaken while stopped, so every setup passes through a stop
  task automatic start(input logic [1:0] m, input logic [15:0] dt, adt, md);
    generator_enable = 1'h0;
    step(2);
    dead_time_mode = m;
    dead_time_value = dt;
    alternate_dead_time_value = adt;
    master_duty = md;
    step(2);
    generator_enable = 1'h1;
    step(40);
  endtask

  // rise to rise of the high pin, counting the cycles each pin is high
  task automatic measure(input logic [23:0] exp);
    int t;
    logic p;
    len = 0;
    hi = 0;
    lo = 0;
    p = 1'h0;
    for (t = 0; t < 600 && high_output !== 1'h0; t++) step(1);
    for (t = 0; t < 600 && high_output !== 1'h1; t++) step(1);
    for (t = 0; t < 600 && !(p && high_output === 1'h1); t++)
    begin
      len++;
      hi += int'(high_output === 1'h1);
      lo += int'(low_output === 1'h1);
      p = p | (high_output !== 1'h1);
      step(1);
    end
    if (exp !== 24'h00_0000)
      check({len[7:0], hi[7:0], lo[7:0]}, exp);
  endtask

  task automatic sample(input logic [15:0] exp);
    hi = 0;
    lo = 0;
    repeat (40)
    begin
      hi += int'(high_output === 1'h1);
      lo += int'(low_output === 1'h1);
      step(1);
    end
    check({hi[7:0], lo[7:0]}, exp);
  endtask

  // exactly four periods, so each enabled trigger with a compare of at least TRIG_MIN fires four times whatever the phase
  task automatic trig(input logic [15:0] exp);
    clear = 1'h1;
    step(40);
    clear = 1'h0;
    step(128);
    check({adc_count[7:0], irq_count[7:0]}, exp);
  endtask

  task automatic pins(input logic [3:0] exp);
    step(3);
    check({high_output, high_output_oe, low_output, low_output_oe}, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  // ********
  // tests
  // ********
  initial
  begin
    step(2);
    sys_rst = 1'h0;
    step(1);
    start(2'h0, 16'h0020, 16'h0030, 16'h0080);
    measure(24'h20_0c0a);
    start(2'h1, 16'h0026, 16'h0010, 16'h0080);
    measure(24'h20_0b0e);
    start(2'h2, 16'h0020, 16'h0030, 16'h0080);
    measure(24'h20_1010);
    done("dead time");
    start(2'h2, 16'h0010, 16'h0010, 16'h0024);
    measure(24'h20_041c);
    start(2'h2, 16'h0010, 16'h0010, 16'h00e4);
    measure(24'h20_1c04);
    start(2'h2, 16'h0010, 16'h0010, 16'h0000);
    sample(16'h0028);
    start(2'h2, 16'h0010, 16'h0010, 16'h000f);
    sample(16'h0028);
    done("duty");
    duty_select = 1'h1;
    individual_duty = 16'h0040;
    start(2'h2, 16'h0010, 16'h0010, 16'h0080);
    measure(24'h20_0818);
    duty_select = 1'h0;
    period_select = 1'h1;
    individual_period = 16'h0200;
    start(2'h2, 16'h0010, 16'h0010, 16'h0080);
    measure(24'h40_1030);
    // an immediate update must not wait for the period end
    immediate_update = 1'h1;
    master_duty = 16'h0000;
    step(5);
    check(high_output, 1'h0);
    immediate_update = 1'h0;
    done("sources");
    // back to a 32-cycle period so the trigger window spans four whole periods
    individual_period = 16'h0100;
    start(2'h2, 16'h0010, 16'h0010, 16'h0080);
    trig(16'h0404);
    trigger_select = 1'h1;
    trig(16'h0404);
    special_event_compare = 16'h0004;
    trig(16'h0000);
    trigger_select = 1'h0;
    adc_trigger_enable = 1'h0;
    trig(16'h0004);
    done("trigger");
    individual_period = 16'h0100;
    current_limit_in = 1'h1;
    current_reset_enable = 1'h1;
    start(2'h2, 16'h0010, 16'h0010, 16'h0080);
    measure(24'h00_0000);
    check(hi, 16);
    check(len > 16 && len < 32, 1);
    current_reset_enable = 1'h0;
    step(40);
    measure(24'h20_1010);
    check(shoot_count, 0);
    done("current reset");
    current_limit_in = 1'h0;
    generator_enable = 1'h0;
    pins(4'h5);
    high_override_enable = 1'h1;
    low_override_enable = 1'h1;
    override_level_bits = 2'h2;
    pins(4'hd);
    override_level_bits = 2'h1;
    pins(4'h7);
    low_override_enable = 1'h0;
    override_level_bits = 2'h3;
    pins(4'hd);
    low_override_enable = 1'h1;
    override_level_bits = 2'h2;
    current_limit_override_enable = 1'h1;
    current_limit_level_bits = 2'h1;
    current_limit_in = 1'h1;
    pins(4'h7);
    fault_override_enable = 1'h1;
    fault_in = 1'h1;
    fault_level_bits = 2'h2;
    pins(4'hd);
    high_pin_ownership = 1'h0;
    port_latch = 2'h1;
    port_direction_out = 2'h3;
    pins(4'h5);
    port_latch = 2'h2;
    port_direction_out = 2'h1;
    pins(4'h9);
    done("pin ownership");
    tally_and_finish();
  end
endmodule

// ==== sim/pspg_power_stage.sv ====
`timescale 1ns/10ps
module pspg_power_stage
(
  input  wire logic clk,
  input  wire logic clear,
  input  wire logic high_output,
  input  wire logic high_output_oe,
  input  wire logic low_output,
  input  wire logic low_output_oe,
  input  wire logic adc_trigger,
  input  wire logic trigger_irq,
  output int        adc_count,
  output int        irq_count,
  output int        shoot_count
);
  // ********
  // half bridge and converter sink
  // ********
  initial shoot_count = 0;
  // both switches on at once shorts the rail; the stage only counts it, it does not stop
  always @(posedge clk)
    if ({high_output, high_output_oe, low_output, low_output_oe} === 4'hf)
      shoot_count <= shoot_count + 1;
  // each pulse starts one conversion or one interrupt
  always @(posedge clk)
  begin
    adc_count <= clear ? 0 : adc_count + int'(adc_trigger === 1'h1);
    irq_count <= clear ? 0 : irq_count + int'(trigger_irq === 1'h1);
  end
endmodule
